// file: design/tsc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_monitor import tsc_pkg::*; #(
    parameter int unsigned BIAS_CYCLES   = BIAS_CYC,
    parameter int unsigned DEGLITCH_CYCS = DEGLITCH_CYC,
    parameter int unsigned PRIO_CYCLES   = PRIO_MON_CYC,
    parameter int unsigned STD_CYCLES    = STD_MON_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Analog comparator results
    input  wire logic              cmp_hot,
    input  wire logic              cmp_cold,
    input  wire logic              cmp_pin_grounded,
    input  wire logic              cmp_pin_above_ref,
    input  wire logic              cmp_die_overtemp,
    // Shared sense pin bias driver
    output logic                   sense_bias_window,
    output logic                   divider_bias_pin_o,
    output logic                   divider_bias_pin_oe,
    // Receiver control and indication
    output logic                   regulator_en,
    output logic                   fault_ind,
    output logic                   done_ind,
    output logic                   irq
);
    localparam logic [TIMER_W-1:0] BIAS_LAST = TIMER_W'(BIAS_CYCLES - 1);
    localparam logic [TIMER_W-1:0] PRIO_LAST = TIMER_W'(PRIO_CYCLES - 1);
    localparam logic [TIMER_W-1:0] STD_LAST  = TIMER_W'(STD_CYCLES - 1);

    tsc_state_t         state_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] mon_last;
    logic [2:0]         ctrl_reg;
    logic [EVT_N-1:0]   mask_reg;
    logic               hot_reg;
    logic               cold_reg;
    logic               ctrl_det_reg;
    logic               fault_reg;
    logic               done_reg;
    logic               hot_f;
    logic               cold_f;
    logic               gnd_f;
    logic               above_f;
    logic               otp_f;
    logic               in_bias;
    logic               in_mon;
    logic               bias_end;
    logic               mon_end;
    logic               enable;
    logic               setup;
    logic               access;
    logic               rd_stat;
    logic               clr_shut;
    logic [31:0]        rd_mux;

    tsc_evt_if ev ();

    assign enable   = ctrl_reg[CTRL_EN_BIT];
    assign in_bias  = state_reg == TSC_BIAS;
    assign in_mon   = state_reg == TSC_MONITOR;
    assign bias_end = in_bias && timer_reg == BIAS_LAST;
    // Shorter period chosen mid-window ends it at once, bias on time
    assign mon_end  = in_mon && timer_reg >= mon_last;
    assign setup    = psel && !penable;
    assign access   = psel && penable && pready;
    assign rd_stat  = access && !pwrite && paddr == IRQ_STAT_ADDR;
    assign clr_shut = access && pwrite && paddr == CTRL_ADDR
                      && pwdata[CTRL_CLR_BIT];

    // ----------------------------------------------------------------
    // Input qualification
    // ----------------------------------------------------------------
    // hot and cold deglitched in bias
    tsc_deglitch #(.CNT_W(18), .STABLE(DEGLITCH_CYCS)) u_hot (
        .clk   (clk),
        .rst   (rst),
        .raw   (cmp_hot),
        .run   (in_bias),
        .level (hot_f)
    );
    tsc_deglitch #(.CNT_W(18), .STABLE(DEGLITCH_CYCS)) u_cold (
        .clk   (clk),
        .rst   (rst),
        .raw   (cmp_cold),
        .run   (in_bias),
        .level (cold_f)
    );
    // Grounded pin only meaningful while the divider is biased
    tsc_deglitch #(.CNT_W(18), .STABLE(DEGLITCH_CYCS)) u_gnd (
        .clk   (clk),
        .rst   (rst),
        .raw   (cmp_pin_grounded),
        .run   (in_bias),
        .level (gnd_f)
    );
    tsc_deglitch #(.CNT_W(2), .STABLE(FAST_STABLE)) u_above (
        .clk   (clk),
        .rst   (rst),
        .raw   (cmp_pin_above_ref),
        .run   (in_mon),
        .level (above_f)
    );
    tsc_deglitch #(.CNT_W(2), .STABLE(FAST_STABLE)) u_otp (
        .clk   (clk),
        .rst   (rst),
        .raw   (cmp_die_overtemp),
        .run   (1'b1),
        .level (otp_f)
    );

    // ----------------------------------------------------------------
    // Measurement cycle
    // ----------------------------------------------------------------
    // window length per packet period
    always_comb begin
        mon_last = ctrl_reg[CTRL_PRIO_BIT] ? PRIO_LAST : STD_LAST;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= TSC_IDLE;
            timer_reg <= '0;
        end else begin
            case (state_reg)
                TSC_IDLE: begin
                    timer_reg <= '0;
                    if (enable) begin
                        state_reg <= TSC_BIAS;
                    end
                end
                TSC_BIAS: begin
                    if (bias_end) begin
                        state_reg <= TSC_MONITOR;
                        timer_reg <= '0;
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                TSC_MONITOR: begin
                    // Period change mid-window may overshoot: restart safe
                    if (mon_end || timer_reg > mon_last) begin
                        state_reg <= enable ? TSC_BIAS : TSC_IDLE;
                        timer_reg <= '0;
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= TSC_IDLE;
                    timer_reg <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sense_bias_window   <= 1'b0;
            divider_bias_pin_o  <= 1'b0;
            divider_bias_pin_oe <= 1'b0;
        end else begin
            sense_bias_window   <= enable && (state_reg == TSC_IDLE
                                   || (in_bias && !bias_end)
                                   || mon_end);
            divider_bias_pin_o  <= 1'b1;
            divider_bias_pin_oe <= enable && (state_reg == TSC_IDLE
                                   || (in_bias && !bias_end)
                                   || mon_end);
        end
    end

    // ----------------------------------------------------------------
    // Temperature and host control state
    // ----------------------------------------------------------------
    // classify at window end
    always_ff @(posedge clk) begin
        if (rst) begin
            hot_reg  <= 1'b0;
            cold_reg <= 1'b0;
        end else if (bias_end) begin
            hot_reg  <= hot_f;
            cold_reg <= cold_f;
        end
    end

    // host requests latch shutdown
    // Latched so a brief host pulse cannot restart the receiver
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_det_reg <= 1'b0;
            fault_reg    <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            if (in_mon && above_f) begin
                ctrl_det_reg <= 1'b1;
            end else if (bias_end) begin
                ctrl_det_reg <= 1'b0;
            end
            if (bias_end && gnd_f) begin
                fault_reg <= 1'b1;
            end else if (clr_shut) begin
                fault_reg <= 1'b0;
            end
            if (in_mon && above_f) begin
                done_reg <= 1'b1;
            end else if (clr_shut) begin
                done_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regulator_en <= 1'b0;
            fault_ind    <= 1'b0;
            done_ind     <= 1'b0;
        end else begin
            regulator_en <= enable && !otp_f && !fault_reg && !done_reg
                            && !hot_reg && !cold_reg;
            fault_ind    <= fault_reg;
            done_ind     <= done_reg && !fault_reg;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign ev.events[EVT_HOT]   = bias_end && hot_f && !hot_reg;
    assign ev.events[EVT_COLD]  = bias_end && cold_f && !cold_reg;
    assign ev.events[EVT_CTRL]  = in_mon && above_f && !ctrl_det_reg;
    assign ev.events[EVT_FAULT] = bias_end && gnd_f && !fault_reg;
    assign ev.events[EVT_DONE]  = in_mon && above_f && !done_reg;
    assign ev.events[EVT_OTP]   = otp_f && !regulator_en && enable;
    assign ev.mask              = mask_reg;
    assign ev.rd_clr            = rd_stat;
    assign irq                  = ev.irq;

    tsc_irq u_irq (
        .clk (clk),
        .rst (rst),
        .ev  (ev.sink)
    );

    // ----------------------------------------------------------------
    // APB registers
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            CTRL_ADDR:     rd_mux[2:0] = {1'b0, ctrl_reg[1:0]};
            STATUS_ADDR: begin
                rd_mux[EVT_HOT]     = hot_reg;
                rd_mux[EVT_COLD]    = cold_reg;
                rd_mux[EVT_CTRL]    = ctrl_det_reg;
                rd_mux[EVT_FAULT]   = fault_reg;
                rd_mux[EVT_DONE]    = done_reg;
                rd_mux[EVT_OTP]     = otp_f;
                rd_mux[ST_BIAS_BIT] = sense_bias_window;
                rd_mux[ST_REG_BIT]  = regulator_en;
                rd_mux[ST_FSM_LSB +: 2] = state_reg;
            end
            IRQ_STAT_ADDR: rd_mux[EVT_N-1:0] = ev.status;
            IRQ_MASK_ADDR: rd_mux[EVT_N-1:0] = mask_reg;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // No wait state: answer prepared during setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && paddr != CTRL_ADDR && paddr != STATUS_ADDR
                       && paddr != IRQ_STAT_ADDR && paddr != IRQ_MASK_ADDR;
            prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= MASK_RESET;
        end else if (access && pwrite) begin
            if (paddr == CTRL_ADDR) begin
                ctrl_reg <= {1'b0, pwdata[CTRL_PRIO_BIT],
                             pwdata[CTRL_EN_BIT]};
            end
            if (paddr == IRQ_MASK_ADDR) begin
                mask_reg <= pwdata[EVT_N-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_bias_drive: assert property (
        sense_bias_window |-> divider_bias_pin_oe && divider_bias_pin_o)
        else $error("bias window without pin drive");
    a_bias_length: assert property (
        in_bias |-> timer_reg <= BIAS_LAST)
        else $error("bias window ran past its length");
    a_bias_release: assert property (
        bias_end |=> !sense_bias_window && !divider_bias_pin_oe)
        else $error("bias pin not released at window end");
    a_mon_hiz: assert property (
        in_mon && !mon_end |=> !divider_bias_pin_oe)
        else $error("bias pin driven while unbiased");
    a_mon_length: assert property (
        in_mon && ctrl_reg[CTRL_PRIO_BIT] && $stable(ctrl_reg)
        |-> timer_reg <= PRIO_LAST)
        else $error("priority watch too long");
    a_ctrl_flag: assert property (
        in_mon && above_f |=> ctrl_det_reg && done_reg)
        else $error("external drive not flagged");
    a_temp_class: assert property (
        bias_end |=> hot_reg == $past(hot_f) && cold_reg == $past(cold_f))
        else $error("temperature state not taken");
    a_fault_shut: assert property (
        fault_reg |=> !regulator_en && fault_ind)
        else $error("fault did not shut receiver");
    a_done_shut: assert property (
        done_reg && !fault_reg |=> !regulator_en && done_ind)
        else $error("done did not shut receiver");
    a_otp_off: assert property (
        otp_f |=> !regulator_en)
        else $error("regulator on in over-temperature");
    a_cycle_repeat: assert property (
        mon_end && enable |=> in_bias && timer_reg == '0)
        else $error("cycle did not restart");
    a_keep_running: assert property (
        enable && !in_bias |-> ##[0:1] !(state_reg == TSC_IDLE) || in_mon)
        else $error("monitoring stopped while enabled");

    c_full_cycle: cover property (mon_end && enable);
    c_fault_seen: cover property ($rose(fault_reg));
    c_done_seen:  cover property ($rose(done_reg));
    c_irq_raised: cover property ($rose(irq));
endmodule // tsc_monitor
`default_nettype wire

// file: design/tsc_pkg.sv
`default_nettype none
package tsc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_KHZ      = 20000;
    localparam int unsigned BIAS_MS      = 24;
    localparam int unsigned DEGLITCH_MS  = 10;
    localparam int unsigned PRIO_MON_MS  = 35;
    localparam int unsigned STD_MON_MS   = 235;
    localparam int unsigned BIAS_CYC     = BIAS_MS * CLK_KHZ;
    localparam int unsigned DEGLITCH_CYC = DEGLITCH_MS * CLK_KHZ;
    localparam int unsigned PRIO_MON_CYC = PRIO_MON_MS * CLK_KHZ;
    localparam int unsigned STD_MON_CYC  = STD_MON_MS * CLK_KHZ;
    localparam int unsigned TIMER_W      = 23;
    localparam int unsigned FAST_STABLE  = 2;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  CTRL_ADDR     = 8'h00;
    localparam logic [7:0]  STATUS_ADDR   = 8'h04;
    localparam logic [7:0]  IRQ_STAT_ADDR = 8'h08;
    localparam logic [7:0]  IRQ_MASK_ADDR = 8'h0C;

    // CTRL fields
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_PRIO_BIT = 1;
    localparam int unsigned CTRL_CLR_BIT  = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    // Event / status bit positions
    localparam int unsigned EVT_N       = 6;
    localparam int unsigned EVT_HOT     = 0;
    localparam int unsigned EVT_COLD    = 1;
    localparam int unsigned EVT_CTRL    = 2;
    localparam int unsigned EVT_FAULT   = 3;
    localparam int unsigned EVT_DONE    = 4;
    localparam int unsigned EVT_OTP     = 5;
    localparam int unsigned ST_BIAS_BIT = 6;
    localparam int unsigned ST_REG_BIT  = 7;
    localparam int unsigned ST_FSM_LSB  = 8;
    localparam logic [5:0]  MASK_RESET  = 6'h00;

    typedef enum logic [1:0] {
        TSC_IDLE    = 2'b00,
        TSC_BIAS    = 2'b01,
        TSC_MONITOR = 2'b11
    } tsc_state_t;

endpackage
`default_nettype wire

// file: design/tsc_evt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tsc_evt_if import tsc_pkg::*; ();
    logic [EVT_N-1:0] events;
    logic [EVT_N-1:0] mask;
    logic             rd_clr;
    logic [EVT_N-1:0] status;
    logic             irq;

    modport src  (output events, output mask, output rd_clr,
                  input status, input irq);
    modport sink (input events, input mask, input rd_clr,
                  output status, output irq);
endinterface
`default_nettype wire

// file: design/tsc_deglitch.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_deglitch import tsc_pkg::*; #(
    parameter int unsigned CNT_W  = 18,
    parameter int unsigned STABLE = DEGLITCH_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Raw level and qualifier
    input  wire logic raw,
    input  wire logic run,
    // Accepted level
    output logic      level
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(STABLE - 1);

    logic             s1_reg;
    logic             s2_reg;
    logic             s3_reg;
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level held when not running: last accepted reading survives
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
            level   <= 1'b0;
        end else if (!run || s2_reg != s3_reg || s3_reg == level) begin
            cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= '0;
            level   <= s3_reg;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule // tsc_deglitch
`default_nettype wire

// file: design/tsc_irq.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_irq import tsc_pkg::*; (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Event side
    tsc_evt_if.sink   ev
);
    logic [EVT_N-1:0] status_next;

    // New events win over the read that clears
    always_comb begin
        status_next = ev.rd_clr ? ev.events : (ev.status | ev.events);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ev.status <= '0;
            ev.irq    <= 1'b0;
        end else begin
            ev.status <= status_next;
            // Mask bit set blocks its event from the line
            ev.irq    <= |(status_next & ~ev.mask);
        end
    end
endmodule // tsc_irq
`default_nettype wire

// file: bench/tsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------
// Host three-state network on the shared pin
// -----------------------------------------
module tsc_host_model (
    // Host GPIO levels
    input  wire logic term,
    input  wire logic fault,
    // Pin comparators seen by the device
    output logic      pin_grounded,
    output logic      pin_above_ref
);
    assign pin_grounded = fault;
    // term low pulls pin to battery unless fault grounds it, else hi-Z
    assign pin_above_ref = ~term & ~fault;
endmodule // tsc_host_model
`default_nettype wire

// file: bench/tsc_monitor_test.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_monitor_test import tsc_pkg::*;;
    localparam int B_CYC = 40;
    localparam int P_CYC = 30;
    localparam int S_CYC = 60;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmp_hot = 1'b0;
    logic        cmp_cold = 1'b0;
    logic        cmp_die_overtemp = 1'b0;
    logic        term = 1'b1;
    logic        fault = 1'b0;
    logic        grounded;
    logic        above_ref;
    logic        sense_bias_window;
    logic        bias_o;
    logic        bias_oe;
    logic        regulator_en;
    logic        fault_ind;
    logic        done_ind;
    logic        irq;
    logic [31:0] rdata;
    logic        slverr;
    int          mismatches = 0;
    int          checked = 0;

    always #25 clk = ~clk;

    tsc_host_model host (.term(term), .fault(fault),
        .pin_grounded(grounded), .pin_above_ref(above_ref));

    tsc_monitor #(.BIAS_CYCLES(B_CYC), .DEGLITCH_CYCS(8),
        .PRIO_CYCLES(P_CYC), .STD_CYCLES(S_CYC)) DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_hot(cmp_hot), .cmp_cold(cmp_cold),
        .cmp_pin_grounded(grounded), .cmp_pin_above_ref(above_ref),
        .cmp_die_overtemp(cmp_die_overtemp),
        .sense_bias_window(sense_bias_window),
        .divider_bias_pin_o(bias_o), .divider_bias_pin_oe(bias_oe),
        .regulator_en(regulator_en), .fault_ind(fault_ind),
        .done_ind(done_ind), .irq(irq));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        slverr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        chk("pready one cycle", 0, pready);
    endtask

    // Counts edges until the bias window shows the wanted level
    task automatic wait_bias(logic v, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sense_bias_window !== v);
    endtask

    task automatic full_window();
        int n;
        wait_bias(1'b0, n);
        wait_bias(1'b1, n);
        wait_bias(1'b0, n);
        repeat (3) @(posedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("bias idle", 0, sense_bias_window);
        apb(1'b0, CTRL_ADDR, 32'h0000_0000);
        chk("ctrl reset", 0, rdata);
        apb(1'b0, IRQ_MASK_ADDR, 32'h0000_0000);
        chk("mask reset", 0, rdata);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped error", 1, slverr);
        chk("unmapped data", 0, rdata);
    endtask

    task automatic t_cycle();
        int n;
        apb(1'b1, CTRL_ADDR, 32'h0000_0003);
        wait_bias(1'b1, n);
        chk("bias pin drive", 1, {bias_oe, bias_o} == 2'b11);
        wait_bias(1'b0, n);
        chk("bias length", B_CYC, n);
        chk("bias pin released", 0, bias_oe);
        wait_bias(1'b1, n);
        chk("priority watch", P_CYC, n);
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        wait_bias(1'b0, n);
        wait_bias(1'b1, n);
        chk("standard watch", S_CYC, n);
    endtask

    task automatic t_temp();
        int n;
        for (int i = 0; i < 2; i++) begin
            cmp_hot  <= (i == 0);
            cmp_cold <= (i == 1);
            full_window();
            chk("regulator on hot or cold", 0, regulator_en);
            chk("irq raised", 1, irq);
            apb(1'b0, STATUS_ADDR, 32'h0000_0000);
            chk("temp class", 32'(1 << i), rdata & 32'h0000_0003);
            apb(1'b0, IRQ_STAT_ADDR, 32'h0000_0000);
            chk("event bit", 1, rdata[i]);
            apb(1'b0, IRQ_STAT_ADDR, 32'h0000_0000);
            chk("event cleared", 0, rdata[i]);
            chk("irq dropped", 0, irq);
            cmp_hot  <= 1'b0;
            cmp_cold <= 1'b0;
            full_window();
            chk("regulator back", 1, regulator_en);
        end
        wait_bias(1'b1, n);
        cmp_hot <= 1'b1;
        repeat (5) @(posedge clk);
        cmp_hot <= 1'b0;
        wait_bias(1'b0, n);
        repeat (3) @(posedge clk);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        chk("short hot ignored", 0, rdata[EVT_HOT]);
    endtask

    task automatic t_mask();
        apb(1'b1, IRQ_MASK_ADDR, 32'h0000_0001);
        cmp_hot <= 1'b1;
        full_window();
        chk("masked irq", 0, irq);
        apb(1'b0, IRQ_STAT_ADDR, 32'h0000_0000);
        chk("masked event kept", 1, rdata[EVT_HOT]);
        cmp_hot <= 1'b0;
        full_window();
        apb(1'b0, IRQ_STAT_ADDR, 32'h0000_0000);
        apb(1'b1, IRQ_MASK_ADDR, 32'h0000_0000);
    endtask

    task automatic t_fault();
        fault <= 1'b1;
        full_window();
        chk("fault shown", 1, fault_ind);
        chk("fault shutdown", 0, regulator_en);
        chk("no done on fault", 0, done_ind);
        fault <= 1'b0;
        apb(1'b1, CTRL_ADDR, 32'h0000_0005);
        repeat (2) @(posedge clk);
        chk("fault cleared", 0, fault_ind);
    endtask

    task automatic t_done();
        int n;
        wait_bias(1'b1, n);
        wait_bias(1'b0, n);
        term <= 1'b0;
        repeat (10) @(posedge clk);
        chk("done shown", 1, done_ind);
        chk("done shutdown", 0, regulator_en);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        chk("control detect", 1, rdata[EVT_CTRL]);
        chk("no fault on done", 0, rdata[EVT_FAULT]);
        term <= 1'b1;
        // Detector must settle, else a new detection beats the clear
        repeat (8) @(posedge clk);
        apb(1'b1, CTRL_ADDR, 32'h0000_0005);
        repeat (2) @(posedge clk);
        chk("done cleared", 0, done_ind);
    endtask

    task automatic t_otp();
        cmp_die_overtemp <= 1'b1;
        repeat (8) @(posedge clk);
        chk("regulator off hot die", 0, regulator_en);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        chk("overtemp status", 1, rdata[EVT_OTP]);
        cmp_die_overtemp <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_cycle();
        t_temp();
        t_mask();
        t_fault();
        t_done();
        t_otp();
        end_of_test();
    end

    // Whole run is a little over a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule // tsc_monitor_test
`default_nettype wire
